// *** rtl/gpc_pkg.sv ***
package gpc_pkg;

	// Pin count of the group slice handled here, C2 up to C6
	localparam int GPC_PINS = 5;
	localparam int GPC_SYNC_STAGES = 2;

	// Register offsets on the register port
	localparam logic [7:0] GPC_MODE_C6_OFS  = 8'h58;
	localparam logic [7:0] GPC_MODE_C54_OFS = 8'h59;
	localparam logic [7:0] GPC_MODE_C32_OFS = 8'h5A;
	localparam logic [7:0] GPC_DATA_OFS     = 8'h5E;

	// Field positions inside a mode register
	localparam int GPC_HI_SEL_BIT  = 7;
	localparam int GPC_HI_MODE_LSB = 4;
	localparam int GPC_LO_SEL_BIT  = 3;
	localparam int GPC_LO_MODE_LSB = 0;
	localparam int GPC_DATA_LSB    = 2;

	// Reset values
	localparam logic [7:0] GPC_MODE_RST = 8'h00;
	localparam logic [2:0] GPC_C6_RST   = 3'h0;
	localparam logic [4:0] GPC_DATA_RST = 5'h00;

	// Pin function codes
	localparam logic [2:0] GPC_MD_GP_IN   = 3'h0;
	localparam logic [2:0] GPC_MD_IRQ     = 3'h1;
	localparam logic [2:0] GPC_MD_ALT_IN  = 3'h2;
	localparam logic [2:0] GPC_MD_KBD_RET = 3'h3;
	localparam logic [2:0] GPC_MD_GP_OUT  = 3'h4;

	// Interrupt line per pin (index 0 is C2), select clear and select set
	localparam logic [3:0] GPC_IRQ_CLR [GPC_PINS] = '{4'hE, 4'hD, 4'hC, 4'hB, 4'hA};
	localparam logic [3:0] GPC_IRQ_SET [GPC_PINS] = '{4'h6, 4'h5, 4'h4, 4'h3, 4'hA};

	// Codes 1xx drive the pin, 0xx leave it as an input
	function automatic logic gpc_is_out(input logic [2:0] mode);
		return mode[2];
	endfunction

	function automatic logic gpc_is_gp_out(input logic [2:0] mode);
		return mode == GPC_MD_GP_OUT;
	endfunction

endpackage

// *** rtl/gpc_sync.sv ***
`timescale 1ns/1ns
module gpc_sync
	import gpc_pkg::*;
#(
	parameter int WIDTH = GPC_PINS
) (
	// Clock and reset
	input  wire logic             i_sys_clk,
	input  wire logic             i_srst,
	// Asynchronous levels in, clean levels out
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta_r;

	// Two stages; the first is read only by the second
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			meta_r <= '0;
			o_sync <= '0;
		end else begin
			meta_r <= i_async;
			o_sync <= meta_r;
		end
	end

endmodule

// *** rtl/gpc_pin_cell.sv ***
`timescale 1ns/1ns
module gpc_pin_cell
	import gpc_pkg::*;
(
	// Function code of this pin
	input  wire logic [2:0] i_mode,
	// Data register bit for general output
	input  wire logic       i_gp_data,
	// Peripheral outputs for codes 101, 110, 111
	input  wire logic [2:0] i_alt_out,
	input  wire logic [2:0] i_alt_ok,
	// Pin drive
	output logic            o_oe,
	output logic            o_out
);

	logic [1:0] alt_idx;

	// Output codes pick a source; reserved output codes leave the pin floating
	always_comb begin
		alt_idx = i_mode[1:0] - 2'h1;
		o_oe    = 1'b0;
		o_out   = 1'b0;
		if (gpc_is_gp_out(i_mode)) begin
			o_oe  = 1'b1;
			o_out = i_gp_data;
		end else if (gpc_is_out(i_mode)) begin
			o_oe  = i_alt_ok[alt_idx];
			o_out = i_alt_ok[alt_idx] & i_alt_out[alt_idx];
		end
	end

endmodule

// *** rtl/gpc_pin_mux.sv ***
// Functional notes
// - C6 code map, fixed IRQ10 interrupt input
// - C5 interrupt: IRQ11, or IRQ3 when selected
// - C5 code map, code 010 reserved
// - C4 interrupt: IRQ12, or IRQ4 when selected
// - C4 code map, code 101 reserved
// - C3 interrupt: IRQ13, or IRQ5 when selected
// - C3 code map, no reserved codes
// - C2 interrupt: IRQ14, or IRQ6 when selected
// - Select bit acts only in interrupt mode
// - Register 59H holds C5 and C4 fields
// - Register 5AH holds C3 and C2 fields
// - Data register drives outputs, reads inputs
`timescale 1ns/1ns
module gpc_pin_mux
	import gpc_pkg::*;
(
	// Clock and reset
	input  wire logic       i_sys_clk,
	input  wire logic       i_srst,
	// Register port
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic      [7:0] o_rdata,
	// Pins C2 to C6, bit 0 is C2
	input  wire logic [4:0] i_pin_in,
	output logic      [4:0] o_pin_out,
	output logic      [4:0] o_pin_oe,
	// Peripheral sources for output functions
	input  wire logic       i_isa_bhe_n,
	input  wire logic       i_pccard_mem_wr_n,
	input  wire logic [2:0] i_pccard_addr_hi,
	input  wire logic       i_aux_serial_transmit,
	input  wire logic       i_chip_select_2_n,
	input  wire logic [3:0] i_keyboard_drive_lines,
	// Peripheral sinks for input functions
	output logic      [15:0] o_irq_req,
	output logic             o_aux_serial_receive,
	output logic      [3:0]  o_keyboard_return_lines,
	output logic             o_iocs16_n,
	output logic             o_memcs16_n
);

	logic [2:0] mode_c6_r;
	logic [7:0] mode_c54_r;
	logic [7:0] mode_c32_r;
	logic [4:0] data_r;
	logic [4:0] pin_s;
	logic [2:0] mode      [GPC_PINS];
	logic [4:0] sel;
	logic [2:0] alt_out   [GPC_PINS];
	logic [2:0] alt_ok    [GPC_PINS];
	logic [4:0] oe_nxt;
	logic [4:0] out_nxt;
	logic [15:0] irq_nxt;
	logic [7:0] rdata_nxt;
	logic [4:0] data_nxt;

	// Field views of the mode registers
	assign mode[0] = mode_c32_r[GPC_LO_MODE_LSB +: 3];
	assign mode[1] = mode_c32_r[GPC_HI_MODE_LSB +: 3];
	assign mode[2] = mode_c54_r[GPC_LO_MODE_LSB +: 3];
	assign mode[3] = mode_c54_r[GPC_HI_MODE_LSB +: 3];
	assign mode[4] = mode_c6_r;
	assign sel = {1'b0, mode_c54_r[GPC_HI_SEL_BIT], mode_c54_r[GPC_LO_SEL_BIT],
		mode_c32_r[GPC_HI_SEL_BIT], mode_c32_r[GPC_LO_SEL_BIT]};

	// Output sources for codes 101, 110, 111; C2 alternates are not carried here
	assign alt_out[0] = 3'h0;
	assign alt_ok[0]  = 3'h0;
	assign alt_out[1] = {i_keyboard_drive_lines[0], i_chip_select_2_n, i_pccard_addr_hi[0]};
	assign alt_ok[1]  = 3'h7;
	assign alt_out[2] = {i_keyboard_drive_lines[1], i_pccard_addr_hi[1], 1'b0};
	assign alt_ok[2]  = 3'h6; // Code 101 is reserved, pin floats
	assign alt_out[3] = {i_keyboard_drive_lines[2], i_pccard_addr_hi[2], i_aux_serial_transmit};
	assign alt_ok[3]  = 3'h7;
	assign alt_out[4] = {i_keyboard_drive_lines[3], i_pccard_mem_wr_n, i_isa_bhe_n};
	assign alt_ok[4]  = 3'h7;

	// Pin levels arrive from outside the clock domain
	gpc_sync #(
		.WIDTH (GPC_PINS)
	) u_sync (
		.i_sys_clk (i_sys_clk),
		.i_srst    (i_srst),
		.i_async   (i_pin_in),
		.o_sync    (pin_s)
	);

	// One drive cell per pin
	genvar gp;
	generate
		for (gp = 0; gp < GPC_PINS; gp++) begin : g_pin
			gpc_pin_cell u_cell (
				.i_mode    (mode[gp]),
				.i_gp_data (data_r[gp]),
				.i_alt_out (alt_out[gp]),
				.i_alt_ok  (alt_ok[gp]),
				.o_oe      (oe_nxt[gp]),
				.o_out     (out_nxt[gp])
			);
		end
	endgenerate

	// Mode registers; reserved codes are stored as written
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			mode_c6_r  <= GPC_C6_RST;
			mode_c54_r <= GPC_MODE_RST;
			mode_c32_r <= GPC_MODE_RST;
		end else if (i_wr) begin
			if (i_addr == GPC_MODE_C6_OFS) begin
				mode_c6_r <= i_wdata[GPC_LO_MODE_LSB +: 3];
			end else if (i_addr == GPC_MODE_C54_OFS) begin
				mode_c54_r <= i_wdata;
			end else if (i_addr == GPC_MODE_C32_OFS) begin
				mode_c32_r <= i_wdata;
			end
		end
	end

	// Data bits take writes only where the pin is a general output
	always_comb begin
		data_nxt = data_r;
		if (i_wr && i_addr == GPC_DATA_OFS) begin
			for (int p = 0; p < GPC_PINS; p++) begin
				if (gpc_is_gp_out(mode[p])) begin
					data_nxt[p] = i_wdata[GPC_DATA_LSB + p];
				end
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			data_r <= GPC_DATA_RST;
		end else begin
			data_r <= data_nxt;
		end
	end

	// Read decode; unmapped addresses return zero
	always_comb begin
		rdata_nxt = 8'h00;
		if (i_addr == GPC_MODE_C6_OFS) begin
			rdata_nxt = {5'h00, mode_c6_r};
		end else if (i_addr == GPC_MODE_C54_OFS) begin
			rdata_nxt = mode_c54_r;
		end else if (i_addr == GPC_MODE_C32_OFS) begin
			rdata_nxt = mode_c32_r;
		end else if (i_addr == GPC_DATA_OFS) begin
			for (int p = 0; p < GPC_PINS; p++) begin
				rdata_nxt[GPC_DATA_LSB + p] = gpc_is_gp_out(mode[p]) ? data_r[p] : pin_s[p];
			end
		end
	end

	// Read data stand for one cycle only
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_rdata <= 8'h00;
		end else begin
			o_rdata <= i_rd ? rdata_nxt : 8'h00;
		end
	end

	// Interrupt routing; select bit is looked at only under the interrupt code
	always_comb begin
		irq_nxt = 16'h0000;
		for (int p = 0; p < GPC_PINS; p++) begin
			if (mode[p] == GPC_MD_IRQ) begin
				if (sel[p]) begin
					irq_nxt[GPC_IRQ_SET[p]] = irq_nxt[GPC_IRQ_SET[p]] | pin_s[p];
				end else begin
					irq_nxt[GPC_IRQ_CLR[p]] = irq_nxt[GPC_IRQ_CLR[p]] | pin_s[p];
				end
			end
		end
	end

	// Registered pin drive and interrupt requests
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_pin_oe  <= 5'h00;
			o_pin_out <= 5'h00;
			o_irq_req <= 16'h0000;
		end else begin
			o_pin_oe  <= oe_nxt;
			o_pin_out <= out_nxt;
			o_irq_req <= irq_nxt;
		end
	end

	// Input functions; idle level is high so an unselected strobe stays inactive
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_aux_serial_receive    <= 1'b1;
			o_keyboard_return_lines <= 4'hF;
			o_iocs16_n              <= 1'b1;
			o_memcs16_n             <= 1'b1;
		end else begin
			o_aux_serial_receive <= (mode[4] == GPC_MD_ALT_IN) ? pin_s[4] : 1'b1;
			o_iocs16_n           <= (mode[2] == GPC_MD_ALT_IN) ? pin_s[2] : 1'b1;
			o_memcs16_n          <= (mode[1] == GPC_MD_ALT_IN) ? pin_s[1] : 1'b1;
			for (int k = 0; k < 4; k++) begin
				o_keyboard_return_lines[k] <= (mode[k + 1] == GPC_MD_KBD_RET) ? pin_s[k + 1] : 1'b1;
			end
		end
	end

	// Checks
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_srst);

	a_c6_irq_fixed: assert property ((mode[4] == GPC_MD_IRQ) |=> o_irq_req[10] == $past(pin_s[4]))
		else $error("C6 interrupt not on line 10");
	a_c5_irq_route: assert property ((mode[3] == GPC_MD_IRQ && sel[3])
		|=> o_irq_req[3] == $past(pin_s[3]) && !o_irq_req[11])
		else $error("C5 interrupt misrouted");
	a_c5_irq_main: assert property ((mode[3] == GPC_MD_IRQ && !sel[3])
		|=> o_irq_req[11] == $past(pin_s[3]) && !o_irq_req[3])
		else $error("C5 interrupt not on its default line");
	a_c4_irq_route: assert property ((mode[2] == GPC_MD_IRQ && !sel[2])
		|=> o_irq_req[12] == $past(pin_s[2]) && !o_irq_req[4])
		else $error("C4 interrupt misrouted");
	a_c4_irq_alt: assert property ((mode[2] == GPC_MD_IRQ && sel[2])
		|=> o_irq_req[4] == $past(pin_s[2]) && !o_irq_req[12])
		else $error("C4 interrupt not on its selected line");
	a_c3_irq_route: assert property ((mode[1] == GPC_MD_IRQ && sel[1])
		|=> o_irq_req[5] == $past(pin_s[1]) && !o_irq_req[13])
		else $error("C3 interrupt misrouted");
	a_c3_irq_main: assert property ((mode[1] == GPC_MD_IRQ && !sel[1])
		|=> o_irq_req[13] == $past(pin_s[1]) && !o_irq_req[5])
		else $error("C3 interrupt not on its default line");
	a_c2_irq_route: assert property ((mode[0] == GPC_MD_IRQ && !sel[0])
		|=> o_irq_req[14] == $past(pin_s[0]) && !o_irq_req[6])
		else $error("C2 interrupt misrouted");
	a_c2_irq_alt: assert property ((mode[0] == GPC_MD_IRQ && sel[0])
		|=> o_irq_req[6] == $past(pin_s[0]) && !o_irq_req[14])
		else $error("C2 interrupt not on its selected line");
	a_irq_gated_off: assert property ((mode[3] != GPC_MD_IRQ) |=> !o_irq_req[3] && !o_irq_req[11])
		else $error("C5 interrupt active outside interrupt mode");
	a_c2_gated_off: assert property ((mode[0] != GPC_MD_IRQ)
		|=> !o_irq_req[6] && !o_irq_req[14])
		else $error("C2 interrupt active outside interrupt mode");
	a_reg59_readback: assert property ((i_wr && i_addr == GPC_MODE_C54_OFS)
		##1 (i_rd && i_addr == GPC_MODE_C54_OFS) |=> o_rdata == $past(i_wdata, 2))
		else $error("Register 59H readback wrong");
	a_reg5a_readback: assert property ((i_wr && i_addr == GPC_MODE_C32_OFS)
		##1 (i_rd && i_addr == GPC_MODE_C32_OFS) |=> o_rdata == $past(i_wdata, 2))
		else $error("Register 5AH readback wrong");
	a_rdata_idle_zero: assert property ((!i_rd)
		|=> o_rdata == 8'h00)
		else $error("Read data present without a read strobe");
	a_c6_bhe_drive: assert property ((mode[4] == 3'h5) |=> o_pin_oe[4] && o_pin_out[4] == $past(i_isa_bhe_n))
		else $error("C6 bus high enable not driven");
	a_c6_memwr_drive: assert property ((mode[4] == 3'h6)
		|=> o_pin_oe[4] && o_pin_out[4] == $past(i_pccard_mem_wr_n))
		else $error("C6 card memory write not driven");
	a_c6_scan_drive: assert property ((mode[4] == 3'h7)
		|=> o_pin_oe[4] && o_pin_out[4] == $past(i_keyboard_drive_lines[3]))
		else $error("C6 keyboard drive line not driven");
	a_c6_in_float: assert property ((!mode[4][2])
		|=> !o_pin_oe[4])
		else $error("C6 input code drives the pin");
	a_c6_rx_sink: assert property ((mode[4] == GPC_MD_ALT_IN)
		|=> o_aux_serial_receive == $past(pin_s[4]))
		else $error("C6 serial receive not passed on");
	a_c6_ret_sink: assert property ((mode[4] == GPC_MD_KBD_RET)
		|=> o_keyboard_return_lines[3] == $past(pin_s[4]))
		else $error("C6 keyboard return not passed on");
	a_c5_tx_drive: assert property ((mode[3] == 3'h5)
		|=> o_pin_oe[3] && o_pin_out[3] == $past(i_aux_serial_transmit))
		else $error("C5 serial transmit not driven");
	a_c5_a22_drive: assert property ((mode[3] == 3'h6) |=> o_pin_oe[3] && o_pin_out[3] == $past(i_pccard_addr_hi[2]))
		else $error("C5 address bit not driven");
	a_c5_reserved_float: assert property ((mode[3] == GPC_MD_ALT_IN)
		|=> !o_pin_oe[3])
		else $error("C5 reserved code drives the pin");
	a_c5_ret_sink: assert property ((mode[3] == GPC_MD_KBD_RET)
		|=> o_keyboard_return_lines[2] == $past(pin_s[3]))
		else $error("C5 keyboard return not passed on");
	a_c4_reserved_float: assert property ((mode[2] == 3'h5) |=> !o_pin_oe[2])
		else $error("C4 reserved code drives the pin");
	a_c4_a21_drive: assert property ((mode[2] == 3'h6)
		|=> o_pin_oe[2] && o_pin_out[2] == $past(i_pccard_addr_hi[1]))
		else $error("C4 address bit not driven");
	a_c4_iocs_sink: assert property ((mode[2] == GPC_MD_ALT_IN)
		|=> o_iocs16_n == $past(pin_s[2]))
		else $error("C4 io size strobe not passed on");
	a_c3_cs2_drive: assert property ((mode[1] == 3'h6) |=> o_pin_oe[1] && o_pin_out[1] == $past(i_chip_select_2_n))
		else $error("C3 chip select not driven");
	a_c3_a20_drive: assert property ((mode[1] == 3'h5)
		|=> o_pin_oe[1] && o_pin_out[1] == $past(i_pccard_addr_hi[0]))
		else $error("C3 address bit not driven");
	a_c3_memcs_sink: assert property ((mode[1] == GPC_MD_ALT_IN)
		|=> o_memcs16_n == $past(pin_s[1]))
		else $error("C3 memory size strobe not passed on");
	a_gp_out_data: assert property ((mode[4] == GPC_MD_GP_OUT) ##1 (mode[4] == GPC_MD_GP_OUT)
		|=> o_pin_oe[4] && o_pin_out[4] == $past(data_r[4]))
		else $error("C6 general output does not follow data");
	a_gp_in_ignore: assert property ((mode[4] == GPC_MD_GP_IN && i_wr && i_addr == GPC_DATA_OFS)
		|=> data_r[4] == $past(data_r[4]))
		else $error("Write to input data bit took effect");

	c_c5_irq_alt: cover property (mode[3] == GPC_MD_IRQ && sel[3] ##1 o_irq_req[3]);
	c_c6_gp_out: cover property (mode[4] == GPC_MD_GP_OUT ##2 o_pin_oe[4] && o_pin_out[4]);
	c_data_read_in: cover property (i_rd && i_addr == GPC_DATA_OFS && mode[0] == GPC_MD_GP_IN);
	c_kbd_return: cover property (mode[2] == GPC_MD_KBD_RET ##1 !o_keyboard_return_lines[1]);

endmodule

// *** dv/testbench.sv ***
`timescale 1ns/1ns
module testbench
	import gpc_pkg::*;
;
	logic        sys_clk, srst, wr, rd, bhe_n, memwr_n, txd, cs2_n;
	logic [7:0]  addr, wdata;
	logic [4:0]  pin_in;
	logic [2:0]  addr_hi;
	logic [3:0]  kdrv;
	logic [7:0]  rdata;
	logic [4:0]  pin_out, pin_oe;
	logic [15:0] irq;
	logic        rxd, iocs_n, memcs_n;
	logic [3:0]  kret;
	logic [31:0] lfsr_st;
	int          err_total, tests_run;
	// Interrupt line per pin, select clear and select set; C6 has one fixed line
	int          irq_clr [5] = '{14, 13, 12, 11, 10};
	int          irq_set [5] = '{6, 5, 4, 3, 10};

	gpc_pin_mux u_gpc_pin_mux (
		.i_sys_clk(sys_clk), .i_srst(srst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
		.o_rdata(rdata), .i_pin_in(pin_in), .o_pin_out(pin_out), .o_pin_oe(pin_oe),
		.i_isa_bhe_n(bhe_n), .i_pccard_mem_wr_n(memwr_n), .i_pccard_addr_hi(addr_hi),
		.i_aux_serial_transmit(txd), .i_chip_select_2_n(cs2_n), .i_keyboard_drive_lines(kdrv),
		.o_irq_req(irq), .o_aux_serial_receive(rxd), .o_keyboard_return_lines(kret),
		.o_iocs16_n(iocs_n), .o_memcs16_n(memcs_n)
	);

	// Free running 25 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// Galois step; fixed seed keeps every run identical
	function automatic logic [31:0] lfsr_next(input logic [31:0] x);
		return x[0] ? ((x >> 1) ^ 32'h80200003) : (x >> 1);
	endfunction

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One-cycle write strobe, launched just after an edge
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	// Write then read of one place with no idle cycle between the strobes, then the cycle after
	task automatic wr_rd_reg(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q, output logic [7:0] z);
		@(posedge sys_clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge sys_clk);
		wr <= 1'b0;
		rd <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1 q = rdata;
		@(posedge sys_clk);
		#1 z = rdata;
	endtask

	// One pin in one function code, every other pin left as a plain input
	task automatic run_case(input int p, input logic [2:0] c, input logic s, input logic v);
		logic [7:0]  m58, m59, m5a, rb, ofs, mexp;
		logic [31:0] r;
		logic [4:0]  pins;
		logic        ex_oe, ex_out;
		logic [15:0] ex_irq;
		logic [3:0]  ex_ret;
		m58 = 8'h00;
		m59 = 8'h00;
		m5a = 8'h00;
		case (p)
			0: m5a[3:0] = {s, c};
			1: m5a[7:4] = {s, c};
			2: m59[3:0] = {s, c};
			3: m59[7:4] = {s, c};
			default: m58[2:0] = c;
		endcase
		lfsr_st = lfsr_next(lfsr_st);
		r = lfsr_st;
		// A general output pin is held at the opposite level, so a read must show the data bit
		pins = (r[4:0] & ~(5'h01 << p)) | (5'(c == 3'h4 ? !v : v) << p);
		@(posedge sys_clk);
		pin_in <= pins;
		bhe_n <= r[5];
		memwr_n <= r[6];
		addr_hi <= r[9:7];
		txd <= r[10];
		cs2_n <= r[11];
		kdrv <= r[15:12];
		wr_reg(GPC_MODE_C6_OFS, m58);
		wr_reg(GPC_MODE_C54_OFS, m59);
		wr_reg(GPC_MODE_C32_OFS, m5a);
		wr_reg(GPC_DATA_OFS, {1'b0, {5{v}}, 2'b00});
		repeat (5) @(posedge sys_clk);
		#1;
		// Only the listed codes drive; reserved and unbuilt C2 codes float
		ex_oe = c[2] && !(p == 2 && c == 3'h5) && !(p == 0 && c != 3'h4);
		case (c)
			3'h4: ex_out = v;
			3'h5: ex_out = (p == 1) ? addr_hi[0] : (p == 3) ? txd : bhe_n;
			3'h6: ex_out = (p == 1) ? cs2_n : (p == 2) ? addr_hi[1] : (p == 3) ? addr_hi[2] : memwr_n;
			default: ex_out = kdrv[(p + 3) % 4];
		endcase
		ex_irq = 16'h0000;
		if (c == 3'h1)
			ex_irq[s ? irq_set[p] : irq_clr[p]] = v;
		ex_ret = 4'hF;
		if (c == 3'h3 && p > 0)
			ex_ret[p-1] = v;
		check({11'h0, pin_oe}, {11'h0, 5'(ex_oe) << p});
		if (ex_oe)
			check({15'h0, pin_out[p]}, {15'h0, ex_out});
		check(irq, ex_irq);
		check({9'h0, rxd, iocs_n, memcs_n, kret},
			{9'h0, p == 4 && c == 3'h2 ? v : 1'b1, p == 2 && c == 3'h2 ? v : 1'b1,
			p == 1 && c == 3'h2 ? v : 1'b1, ex_ret});
		ofs = (p == 4) ? GPC_MODE_C6_OFS : (p > 1) ? GPC_MODE_C54_OFS : GPC_MODE_C32_OFS;
		mexp = (p == 4) ? m58 : (p > 1) ? m59 : m5a;
		rd_reg(ofs, rb);
		check({8'h0, rb}, {8'h0, mexp});
		rd_reg(GPC_DATA_OFS, rb);
		check({8'h0, rb & 8'h7C}, {8'h0, 1'b0, (pins & ~(5'h01 << p)) | (5'(v) << p), 2'b00});
	endtask

	task automatic conclude();
		$display("Checks run %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Main sequence: reset values, odd addresses, then every code of every pin
	initial begin
		logic [7:0] rb, rb2;
		err_total = 0;
		tests_run = 0;
		lfsr_st = 32'h5bc4;
		srst = 1'b1;
		{wr, rd, addr, wdata, pin_in, bhe_n, memwr_n, addr_hi, txd, cs2_n, kdrv} = '0;
		repeat (8) @(posedge sys_clk);
		srst <= 1'b0;
		rd_reg(GPC_MODE_C54_OFS, rb);
		check({8'h0, rb}, 16'h0000);
		// Outputs after reset: nothing driven, no request, sinks idle high
		check({6'h0, pin_oe, pin_out}, 16'h0000);
		check(irq, 16'h0000);
		check({9'h0, rxd, iocs_n, memcs_n, kret}, 16'h007F);
		rd_reg(GPC_MODE_C32_OFS, rb);
		check({8'h0, rb}, 16'h0000);
		// Unmapped place swallows writes and reads zero
		wr_reg(8'h40, 8'hA5);
		rd_reg(8'h40, rb);
		check({8'h0, rb}, 16'h0000);
		wr_reg(GPC_MODE_C6_OFS, 8'hFF);
		rd_reg(GPC_MODE_C6_OFS, rb);
		check({8'h0, rb}, 16'h0007);
		// Back to back strobes with random fields, then the idle cycle after the read
		for (int n = 0; n < 8; n++) begin
			lfsr_st = lfsr_next(lfsr_st);
			wr_rd_reg(GPC_MODE_C54_OFS, lfsr_st[7:0], rb, rb2);
			check({8'h0, rb}, {8'h0, lfsr_st[7:0]});
			check({8'h0, rb2}, 16'h0000);
			wr_rd_reg(GPC_MODE_C32_OFS, lfsr_st[15:8], rb, rb2);
			check({8'h0, rb}, {8'h0, lfsr_st[15:8]});
			check({8'h0, rb2}, 16'h0000);
		end
		for (int p = 0; p < 5; p++)
			for (int c = 0; c < 8; c++)
				for (int k = 0; k < 4; k++)
					run_case(p, 3'(c), k[1], k[0]);
		// Reset in mid-run must drop the drive left by the last case
		@(posedge sys_clk);
		srst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		srst <= 1'b0;
		rd_reg(GPC_MODE_C6_OFS, rb);
		check({8'h0, rb}, 16'h0000);
		check({11'h0, pin_oe}, 16'h0000);
		check(irq, 16'h0000);
		conclude();
	end

	// Watchdog: 160 cases of about 18 cycles each fit well inside this span
	initial begin
		repeat (12000) @(posedge sys_clk);
		err_total++;
		conclude();
	end
endmodule
